// file: design/srd_stepper_core.sv
// step rate, position readback, fault mask/status and phase-current lookup
`timescale 1ns/10ps
module srd_stepper_core
   import srd_pkg::*;
#(
   parameter int CLK_RATE_HZ = CLK_HZ
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [15:0] regRdData,
   output logic [15:0] statusWord,
   input wire logic [2:0] msMode,
   input wire logic stepDir,
   input wire logic seqRun,
   input wire logic useRunRate,
   input wire logic homeReq,
   input wire logic faultClear,
   input wire logic serialErr,
   input wire logic overtempPin,
   input wire logic tempWarnPin,
   input wire logic overvoltPin,
   input wire logic undervoltPin,
   input wire logic openLoadAPin,
   input wire logic openLoadBPin,
   input wire logic [7:0] switchOcPin,
   output logic stepTick,
   output logic [5:0] phaseACode,
   output logic phaseAPol,
   output logic [5:0] phaseBCode,
   output logic phasePolB
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [5:0] startRate_reg, startRate_next;
   logic [5:0] runRate_reg, runRate_next;
   logic [15:0] mask_reg, mask_next;
   logic [5:0] angle_reg, angle_next;
   logic dir_reg, dir_next;
   logic [ACC_W-1:0] acc_reg, acc_next;
   logic tick_reg, tick_next;
   logic [5:0] codeA_reg, codeA_next, codeB_reg, codeB_next;
   logic polA_reg, polA_next, polB_reg, polB_next;
   logic [5:0] faults_reg, faults_next;
   logic [7:0] swOc_reg, swOc_next;
   logic por_reg, por_next, serErr_reg, serErr_next;
   logic [15:0] rd_reg, rd_next, status_reg, status_next;
   logic [13:0] sync1_reg, sync2_reg;
   logic [13:0] pinVec;

   ////////////////////////////////////////////////////////////////////////////
   // two-stage synchroniser for analog fault pins
   assign pinVec = {switchOcPin, openLoadBPin, openLoadAPin, undervoltPin, overvoltPin,
      tempWarnPin, overtempPin};

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= pinVec;
         sync2_reg <= sync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lookup helpers
   function automatic logic [5:0] quarter_code(input logic [4:0] k);
      quarter_code = (k > 5'd16) ? SINE_Q[5'd0 - k] : SINE_Q[k];
   endfunction : quarter_code

   function automatic srd_res_t decode_res(input logic [2:0] ms);
      case (ms)
         3'h0, 3'h1: decode_res = SRD_FULL;
         3'h2, 3'h3: decode_res = SRD_HALF;
         3'h4: decode_res = SRD_QUARTER;
         3'h5: decode_res = SRD_EIGHTH;
         default: decode_res = SRD_SIXTEENTH;
      endcase
   endfunction : decode_res

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      logic [10:0] fullRate;
      logic [14:0] ustepRate;
      logic [ACC_W-1:0] accSum;
      logic [5:0] stepSize;
      logic [5:0] angleB;
      logic [5:0] det;
      logic [7:0] swDet;
      logic [5:0] faultsNow;
      fullRate = '0;
      ustepRate = '0;
      accSum = '0;
      stepSize = '0;
      angleB = '0;
      det = '0;
      swDet = '0;
      faultsNow = '0;
      startRate_next = startRate_reg;
      runRate_next = runRate_reg;
      mask_next = mask_reg;
      angle_next = angle_reg;
      dir_next = stepDir;
      acc_next = acc_reg;
      tick_next = 1'b0;

      // host writes; read-only addresses fall through untouched
      if (regWrEn)
      begin
         case (regAddr)
            ADDR_START_RATE: startRate_next = regWrData[RATE_LSB +: RATE_W];
            ADDR_RUN_RATE: runRate_next = regWrData[RATE_LSB +: RATE_W];
            ADDR_FAULT_MASK: mask_next = regWrData & 16'h079E;
            default: mask_next = mask_reg;
         endcase
      end

      // full-step rate, scaled to microsteps by resolution
      if (useRunRate)
         fullRate = 11'({5'h0, runRate_reg} + 11'h001) * RUN_RATE_MULT;
      else
         fullRate = 11'({5'h0, startRate_reg} + 11'h001) * START_RATE_MULT;
      case (decode_res(msMode))
         SRD_FULL: stepSize = 6'h10;
         SRD_HALF: stepSize = 6'h08;
         SRD_QUARTER: stepSize = 6'h04;
         SRD_EIGHTH: stepSize = 6'h02;
         SRD_SIXTEENTH: stepSize = 6'h01;
         default: stepSize = 6'h01;
      endcase
      case (stepSize)
         6'h10: ustepRate = 15'({4'h0, fullRate});
         6'h08: ustepRate = 15'({4'h0, fullRate} << 1);
         6'h04: ustepRate = 15'({4'h0, fullRate} << 2);
         6'h02: ustepRate = 15'({4'h0, fullRate} << 3);
         default: ustepRate = 15'({4'h0, fullRate} << 4);
      endcase

      // phase accumulator divider yields the microstep enable
      if (seqRun)
      begin
         accSum = acc_reg + ACC_W'(ustepRate);
         if (accSum >= ACC_W'(CLK_RATE_HZ))
         begin
            acc_next = accSum - ACC_W'(CLK_RATE_HZ);
            tick_next = 1'b1;
         end
         else
            acc_next = accSum;
      end
      else
         acc_next = '0;

      if (homeReq)
         angle_next = (msMode == MS_ONE_PHASE) ? HOME_ANGLE_ONE_PHASE : HOME_ANGLE;
      else if (tick_next)
         angle_next = stepDir ? angle_reg - stepSize : angle_reg + stepSize;

      // current codes and polarities from the 64-entry cycle
      angleB = angle_next + 6'h10;
      codeA_next = quarter_code(angle_next[4:0]);
      polA_next = angle_next[5] && (angle_next[4:0] != 5'h00);
      codeB_next = quarter_code(angleB[4:0]);
      polB_next = (angle_next > 6'h10) && (angle_next <= 6'h30);

      // masked detection, sticky until cleared, set beats clear
      det[0] = sync2_reg[0] && !mask_reg[OVERTEMP_BIT];
      det[1] = sync2_reg[1] && !mask_reg[TEMP_WARNING_BIT];
      det[2] = sync2_reg[2] && !mask_reg[OVERVOLTAGE_BIT];
      det[3] = sync2_reg[3] && !mask_reg[UNDERVOLTAGE_BIT];
      det[4] = sync2_reg[4] && !mask_reg[A_OPEN_LOAD_BIT];
      det[5] = sync2_reg[5] && !mask_reg[B_OPEN_LOAD_BIT];
      swDet[3:0] = sync2_reg[9:6] & {4{!mask_reg[A_OVERCURRENT_BIT]}};
      swDet[7:4] = sync2_reg[13:10] & {4{!mask_reg[B_OVERCURRENT_BIT]}};
      faults_next = (faultClear ? 6'h00 : faults_reg) | det;
      swOc_next = (faultClear ? 8'h00 : swOc_reg) | swDet;
      por_next = por_reg && !faultClear;
      serErr_next = (serErr_reg && !faultClear) || serialErr;
      faultsNow = faults_next;

      status_next = '0;
      status_next[OVERTEMP_BIT] = faultsNow[0];
      status_next[TEMP_WARNING_BIT] = faultsNow[1];
      status_next[OVERVOLTAGE_BIT] = faultsNow[2];
      status_next[UNDERVOLTAGE_BIT] = faultsNow[3];
      status_next[A_OPEN_LOAD_BIT] = faultsNow[4];
      status_next[B_OPEN_LOAD_BIT] = faultsNow[5];
      status_next[A_OVERCURRENT_BIT] = |swOc_next[3:0];
      status_next[B_OVERCURRENT_BIT] = |swOc_next[7:4];
      status_next[SEQ_ACTIVE_BIT] = seqRun;
      status_next[CMD_READY_BIT] = !seqRun;
      status_next[SERIAL_ERROR_BIT] = serErr_next;
      status_next[POWER_ON_BIT] = por_next;
      status_next[ANY_FAULT_BIT] = (|faultsNow) || (|swOc_next) || por_next || serErr_next;

      // read mux; unmapped addresses answer zero
      rd_next = rd_reg;
      if (regRdEn)
      begin
         rd_next = '0;
         case (regAddr)
            ADDR_START_RATE: rd_next[RATE_LSB +: RATE_W] = startRate_reg;
            ADDR_RUN_RATE: rd_next[RATE_LSB +: RATE_W] = runRate_reg;
            ADDR_POSITION:
            begin
               rd_next[DIR_BIT] = dir_reg;
               rd_next[ANGLE_LSB +: ANGLE_W] = angle_reg;
            end
            ADDR_FAULT_MASK: rd_next = mask_reg;
            ADDR_SWITCH_DIAG: rd_next[DIAG_LSB +: 8] = swOc_reg;
            default: rd_next = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         startRate_reg <= RATE_RESET;
         runRate_reg <= RATE_RESET;
         mask_reg <= MASK_RESET;
         angle_reg <= HOME_ANGLE;
         dir_reg <= 1'b0;
         acc_reg <= '0;
         tick_reg <= 1'b0;
         codeA_reg <= 6'h2C;
         codeB_reg <= 6'h2C;
         polA_reg <= 1'b0;
         polB_reg <= 1'b0;
         faults_reg <= '0;
         swOc_reg <= '0;
         por_reg <= 1'b1;
         serErr_reg <= 1'b0;
         rd_reg <= '0;
         status_reg <= '0;
      end
      else
      begin
         startRate_reg <= startRate_next;
         runRate_reg <= runRate_next;
         mask_reg <= mask_next;
         angle_reg <= angle_next;
         dir_reg <= dir_next;
         acc_reg <= acc_next;
         tick_reg <= tick_next;
         codeA_reg <= codeA_next;
         codeB_reg <= codeB_next;
         polA_reg <= polA_next;
         polB_reg <= polB_next;
         faults_reg <= faults_next;
         swOc_reg <= swOc_next;
         por_reg <= por_next;
         serErr_reg <= serErr_next;
         rd_reg <= rd_next;
         status_reg <= status_next;
      end
   end

   assign regRdData = rd_reg;
   assign statusWord = status_reg;
   assign stepTick = tick_reg;
   assign phaseACode = codeA_reg;
   assign phaseAPol = polA_reg;
   assign phaseBCode = codeB_reg;
   assign phasePolB = polB_reg;
endmodule : srd_stepper_core

// file: dv/srd_core_props.sv
// checker of status, stepping, home and read port relations
`timescale 1ns/10ps
module srd_core_props
   import srd_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] regAddr,
   input wire logic regRdEn,
   input wire logic [15:0] regRdData,
   input wire logic [15:0] statusWord,
   input wire logic [2:0] msMode,
   input wire logic seqRun,
   input wire logic homeReq,
   input wire logic faultClear,
   input wire logic stepTick,
   input wire logic [5:0] phaseACode,
   input wire logic phaseAPol,
   input wire logic [5:0] phaseBCode,
   input wire logic phasePolB
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence s_was_home;
      $past(resetn) && $past(homeReq);
   endsequence
   a_run_bits: assert property ($past(resetn) |->
      statusWord[11] == $past(seqRun) && statusWord[12] == !$past(seqRun))
      else $error("run status bits wrong");
   a_tick_run: assert property (stepTick |-> $past(seqRun))
      else $error("tick without run");
   a_tick_moves: assert property (stepTick && !$past(homeReq) |->
      phaseACode != $past(phaseACode) || phaseBCode != $past(phaseBCode)
      || phaseAPol != $past(phaseAPol) || phasePolB != $past(phasePolB))
      else $error("tick left codes unchanged");
   a_home_two: assert property (s_was_home |-> ($past(msMode) == MS_ONE_PHASE) ||
      (phaseACode == 6'h2C && phaseBCode == 6'h2C && !phaseAPol && !phasePolB))
      else $error("home codes wrong");
   a_home_one: assert property (s_was_home |-> ($past(msMode) != MS_ONE_PHASE) ||
      (phaseACode == 6'h00 && phaseBCode == 6'h3F))
      else $error("one phase home codes wrong");
   a_unmapped_zero: assert property (regRdEn && regAddr < ADDR_START_RATE |=>
      regRdData == 16'h0000) else $error("unmapped read not zero");
   a_read_hold: assert property (!regRdEn |=> $stable(regRdData))
      else $error("read data moved");
   a_spare_zero: assert property (statusWord[0] == 1'b0 && statusWord[6:5] == 2'h0)
      else $error("spare status bits set");
   a_ot_sticky: assert property (statusWord[10] && !faultClear |=> statusWord[10])
      else $error("fault bit lost");
endmodule : srd_core_props

// file: dv/srd_host_model.sv
// host side of the register port: single word writes and reads
`timescale 1ns/10ps
module srd_host_model
(
   input wire logic clk,
   output logic [3:0] regAddr,
   output logic [15:0] regWrData,
   output logic regWrEn,
   output logic regRdEn,
   input wire logic [15:0] regRdData
);
   initial
   begin
      regAddr = 4'h0;
      regWrData = 16'h0000;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(posedge clk);
      #1;
      regWrEn = 1'b0;
      regWrData = ~d;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      #1;
      regAddr = a;
      regRdEn = 1'b1;
      @(posedge clk);
      #1;
      regRdEn = 1'b0;
      regAddr = ~a;
      d = regRdData;
   endtask : rd
endmodule : srd_host_model

// file: dv/srd_stepper_core_tb.sv
// testbench of the rate, readback, fault and phase lookup block
`timescale 1ns/10ps
module srd_stepper_core_tb
   import srd_pkg::*;
;
   localparam int FLD [8] = '{15, 15, 63, 7, 31, 15, 0, 7};
   localparam logic [7:0] RUNM = 8'h4B;
   localparam int FBIT [6] = '{10, 9, 8, 7, 3, 4};
   logic clk = 1'b0, resetn = 1'b0, stepDir = 1'b0, seqRun = 1'b0, useRunRate = 1'b0;
   logic homeReq = 1'b0, faultClear = 1'b0, serialErr = 1'b0;
   logic [2:0] msMode = 3'h6;
   logic [5:0] pins = 6'h00, phaseACode, phaseBCode;
   logic [7:0] oc = 8'h00;
   logic [3:0] regAddr;
   logic [15:0] regWrData, regRdData, statusWord, rd;
   logic regWrEn, regRdEn, stepTick, phaseAPol, phasePolB;
   int miscompares = 0, tests_run = 0;
   wire logic [15:0] codes = {2'b00, phaseAPol, phaseACode, phasePolB, phaseBCode};
   always #4 clk = ~clk;
   srd_host_model u_srd_host_model (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));
   srd_stepper_core #(.CLK_RATE_HZ(16000)) u_srd_stepper_core (.clk(clk), .resetn(resetn),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .statusWord(statusWord), .msMode(msMode), .stepDir(stepDir),
      .seqRun(seqRun), .useRunRate(useRunRate), .homeReq(homeReq), .faultClear(faultClear),
      .serialErr(serialErr), .overtempPin(pins[0]), .tempWarnPin(pins[1]), .overvoltPin(pins[2]),
      .undervoltPin(pins[3]), .openLoadAPin(pins[4]), .openLoadBPin(pins[5]),
      .switchOcPin(oc), .stepTick(stepTick), .phaseACode(phaseACode), .phaseAPol(phaseAPol),
      .phaseBCode(phaseBCode), .phasePolB(phasePolB));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [5:0] mag(input int x);
      return SINE_Q[(x % 32 <= 16) ? x % 32 : 32 - x % 32];
   endfunction : mag
   function automatic logic [15:0] exp_codes(input int a);
      return {2'b00, a > 32, mag(a), a > 16 && a <= 48, mag(a + 16)};
   endfunction : exp_codes
   task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk16
   task automatic chk_rng(input string n, input int lo, input int hi, input int g);
      tests_run++;
      if (g < lo || g > hi)
      begin
         miscompares++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask : chk_rng
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      chk16("status", 16'hD000, statusWord);
      chk16("codes", exp_codes(8), codes);
      u_srd_host_model.rd(ADDR_FAULT_MASK, rd);
      chk16("mask", MASK_RESET, rd);
      u_srd_host_model.wr(ADDR_FAULT_MASK, 16'hFFFF);
      u_srd_host_model.rd(ADDR_FAULT_MASK, rd);
      chk16("mask", 16'h079E, rd);
      u_srd_host_model.wr(ADDR_START_RATE, 16'hFFFF);
      u_srd_host_model.rd(ADDR_START_RATE, rd);
      chk16("start rate", 16'h007E, rd);
      u_srd_host_model.wr(ADDR_POSITION, 16'hFFFF);
      u_srd_host_model.wr(ADDR_SWITCH_DIAG, 16'hFFFF);
      u_srd_host_model.rd(ADDR_POSITION, rd);
      chk16("position", 16'h0010, rd);
      u_srd_host_model.rd(ADDR_SWITCH_DIAG, rd);
      chk16("diag", 16'h0000, rd);
      u_srd_host_model.rd(4'h3, rd);
      chk16("unmapped", 16'h0000, rd);
      u_srd_host_model.wr(ADDR_FAULT_MASK, 16'h0000);
      $display("test regs done");
   endtask : t_regs
   task automatic t_rate(input int m);
      int k;
      int ang;
      int st;
      logic [15:0] f;
      k = 0;
      st = 16 >> ((m < 2) ? 0 : (m < 4) ? 1 : (m > 6) ? 4 : m - 2);
      f = 16'(FLD[m] << 1);
      msMode = 3'(m);
      stepDir = 1'(m % 2);
      useRunRate = RUNM[m];
      u_srd_host_model.wr(ADDR_START_RATE, RUNM[m] ? 16'h007E : f);
      u_srd_host_model.wr(ADDR_RUN_RATE, RUNM[m] ? f : 16'h007E);
      homeReq = 1'b1;
      step(1);
      homeReq = 1'b0;
      ang = (m == 1) ? 0 : 8;
      chk16("home codes", exp_codes(ang), codes);
      seqRun = 1'b1;
      repeat (3850)
      begin
         step(1);
         k += int'(stepTick === 1'b1);
      end
      chk16("run bits", 16'h0800, statusWord & 16'h1800);
      seqRun = 1'b0;
      step(2);
      chk_rng("ticks", 61, 61, k);
      ang = (ang + ((m % 2) ? 64 - st : st) * k) % 64;
      u_srd_host_model.rd(ADDR_POSITION, rd);
      chk16("position", 16'(((m % 2) << 10) | (ang << 1)), rd);
      chk16("codes", exp_codes(ang), codes);
      $display("test rate mode %0d done", m);
   endtask : t_rate
   task automatic t_faults();
      int b;
      for (int i = 0; i < 14; i++)
      begin
         b = (i < 6) ? FBIT[i] : (i < 10) ? 1 : 2;
         u_srd_host_model.wr(ADDR_FAULT_MASK, 16'h0001 << b);
         pins = (i < 6) ? 6'(1 << i) : 6'h00;
         oc = (i < 6) ? 8'h00 : 8'(1 << (i - 6));
         step(5);
         chk16("masked", 16'h0000, statusWord & (16'h0001 << b));
         u_srd_host_model.wr(ADDR_FAULT_MASK, 16'h0000);
         step(5);
         chk16("fault bit", 16'h0001 << b, statusWord & (16'h0001 << b));
         u_srd_host_model.rd(ADDR_SWITCH_DIAG, rd);
         chk16("switch flags", (i < 6) ? 16'h0000 : 16'h0002 << (i - 6), rd);
         pins = 6'h00;
         oc = 8'h00;
         step(3);
         faultClear = 1'b1;
         step(1);
         faultClear = 1'b0;
         step(4);
         chk16("cleared", 16'h0000, statusWord & 16'h079E);
      end
      serialErr = 1'b1;
      step(1);
      serialErr = 1'b0;
      step(1);
      chk16("serial error", 16'hB000, statusWord);
      faultClear = 1'b1;
      step(1);
      faultClear = 1'b0;
      step(1);
      chk16("all clear", 16'h1000, statusWord);
      $display("test faults done");
   endtask : t_faults
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   initial
   begin
      step(10);
      resetn = 1'b1;
      step(2);
      t_regs();
      for (int m = 0; m < 8; m++)
         t_rate(m);
      t_faults();
      final_report();
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      miscompares++;
      final_report();
   end
endmodule : srd_stepper_core_tb
bind srd_stepper_core srd_core_props u_srd_core_props (.clk(clk), .resetn(resetn),
   .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData), .statusWord(statusWord),
   .msMode(msMode), .seqRun(seqRun), .homeReq(homeReq), .faultClear(faultClear),
   .stepTick(stepTick), .phaseACode(phaseACode), .phaseAPol(phaseAPol),
   .phaseBCode(phaseBCode), .phasePolB(phasePolB));

// file: inc/srd_pkg.sv
// register map, field layout and timing constants of the rate, readback and fault block
package srd_pkg;
   localparam logic [3:0] ADDR_START_RATE = 4'hB;
   localparam logic [3:0] ADDR_RUN_RATE = 4'hC;
   localparam logic [3:0] ADDR_POSITION = 4'hD;
   localparam logic [3:0] ADDR_FAULT_MASK = 4'hE;
   localparam logic [3:0] ADDR_SWITCH_DIAG = 4'hF;
   localparam int RATE_LSB = 1;
   localparam int RATE_W = 6;
   localparam int ANGLE_LSB = 1;
   localparam int ANGLE_W = 6;
   localparam int DIR_BIT = 10;
   localparam int DIAG_LSB = 1;
   localparam int A_OVERCURRENT_BIT = 1;
   localparam int B_OVERCURRENT_BIT = 2;
   localparam int A_OPEN_LOAD_BIT = 3;
   localparam int B_OPEN_LOAD_BIT = 4;
   localparam int UNDERVOLTAGE_BIT = 7;
   localparam int OVERVOLTAGE_BIT = 8;
   localparam int TEMP_WARNING_BIT = 9;
   localparam int OVERTEMP_BIT = 10;
   localparam int SEQ_ACTIVE_BIT = 11;
   localparam int CMD_READY_BIT = 12;
   localparam int SERIAL_ERROR_BIT = 13;
   localparam int POWER_ON_BIT = 14;
   localparam int ANY_FAULT_BIT = 15;
   localparam logic [10:0] START_RATE_MULT = 11'h002;
   localparam logic [10:0] RUN_RATE_MULT = 11'h010;
   localparam logic [5:0] HOME_ANGLE = 6'h08;
   localparam logic [5:0] HOME_ANGLE_ONE_PHASE = 6'h00;
   localparam logic [5:0] RATE_RESET = 6'h00;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [2:0] MS_ONE_PHASE = 3'h1;
   localparam int CLK_HZ = 125000000;
   localparam int ACC_W = 28;
   typedef enum {SRD_FULL, SRD_HALF, SRD_QUARTER, SRD_EIGHTH, SRD_SIXTEENTH} srd_res_t;
   // quarter-wave current codes for angles 0..16
   localparam logic [5:0] SINE_Q [0:16] = '{6'h00, 6'h05, 6'h0B, 6'h12, 6'h17, 6'h1D,
      6'h23, 6'h28, 6'h2C, 6'h30, 6'h34, 6'h37, 6'h3A, 6'h3C, 6'h3E, 6'h3F, 6'h3F};
endpackage : srd_pkg
